//--- include/pbs_pkg.sv
/*
  constants, timing figures and state type of the pushbutton power sequencer.
  assumes a 10 MHz system clock and a 1 ms internal time base.
*/
// Notes on behaviour
// - after reset the supply switch is off and converters stay disabled
// - supply turns on only after the button is low 32 ms plus extension
// - an extra turn-on hold time from turn_on_extension adds to the debounce
// - a button release during turn-on debounce restarts the count
// - turning the supply on starts a 512 ms blanking timer
// - during blanking neither shutdown request nor button is sampled
// - shutdown request still low after blanking aborts the power-on
// - after blanking the button release is debounced for 32 ms
// - in on state a 32 ms low press raises the power-down request
// - the power-down request stays low for at least 32 ms
// - then the request follows the button until button or supply releases
// - button still low after the 32 ms request starts the forced-off hold timer
// - release before hold timer ends drops the request, supply stays on
// - hold timer completing releases supply and request at once
// - forced-off press time is 64 ms plus off_hold_extension
// - after blanking a low shutdown request turns the supply off at once
// - after a shutdown-request turn-off the button is ignored for 256 ms
// - after turn-off wait for a new falling button edge
// - the supply switch polarity is chosen by a variant parameter
// - a shutdown request low pulse counts only if at least 30 us long
`default_nettype none
package pbs_pkg;

  // ****************************************************************
  // clock and time base
  // ****************************************************************
  localparam int CLK_NS       = 100;
  localparam int TICK_NS      = 1000000;
  localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;

  // ****************************************************************
  // sequence timings, in 1 ms ticks
  // ****************************************************************
  localparam int TW                       = 17;
  localparam int TURN_ON_DEBOUNCE_MS      = 32;
  localparam int STARTUP_BLANKING_MS      = 512;
  localparam int RELEASE_DEBOUNCE_MS      = 32;
  localparam int TURN_OFF_DEBOUNCE_MS     = 32;
  localparam int FORCED_OFF_MIN_MS        = 64;
  localparam int REQ_MIN_MS               = FORCED_OFF_MIN_MS - TURN_OFF_DEBOUNCE_MS;
  localparam int LOCKOUT_MS               = 256;

  // ****************************************************************
  // shutdown request glitch filter, in clock cycles (least time, round up)
  // ****************************************************************
  localparam int KILL_PW_NS  = 30000;
  localparam int KILL_PW_CYC = (KILL_PW_NS + CLK_NS - 1) / CLK_NS;
  localparam int KW          = 9;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic SYNC_RST   = 1'h1;
  localparam logic PDREQ_RST  = 1'h1;

  typedef enum logic [3:0] {
    ST_OFF, ST_ON_DB, ST_BLANK, ST_REL_DB, ST_ON,
    ST_OFF_DB, ST_REQ_MIN, ST_HOLD, ST_LOCKOUT
  } pbs_state_type;

  // narrow a tick count to the timer width
  function automatic logic [TW-1:0] pbs_ms(input int ms);
    return TW'(ms);
  endfunction

endpackage
`default_nettype wire

//--- include/pbs_tmr_if.sv
/*
  carrier between the sequencer and its millisecond timer.
  assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface pbs_tmr_if;
  import pbs_pkg::*;
  logic          clr;    // restart count at next edge
  logic [TW-1:0] limit;  // ticks until done
  logic          done;   // count has reached limit

  modport ctl (output clr, output limit, input done);
  modport tmr (input clr, input limit, output done);
endinterface
`default_nettype wire

//--- rtl/pbs_timer.sv
/*
  millisecond timer: own clock divider making the 1 ms tick, tick counter.
  assumes clr is asserted on every state entry by the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module pbs_timer
  import pbs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  pbs_tmr_if.tmr    t
);
  logic [13:0]   div_r;
  logic [TW-1:0] cnt_r;
  logic          tick;

  // ****************************************************************
  // time base
  // ****************************************************************
  // divider restarts with the count so every interval is exact
  assign tick = (div_r == 14'(TICK_CYC - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= 14'h0;
    end else if (t.clr || tick) begin
      div_r <= 14'h0;
    end else begin
      div_r <= div_r + 14'h1;
    end
  end

  // ****************************************************************
  // tick counter
  // ****************************************************************
  // saturates so a held state never wraps back below its limit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (t.clr) begin
      cnt_r <= '0;
    end else if (tick && !(&cnt_r)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign t.done = (cnt_r >= t.limit);
endmodule // pbs_timer
`default_nettype wire

//--- rtl/pbs_sequencer.sv
/*
  pushbutton power sequencer: debounce, supply switch, power-down request.
  assumes inputs are asynchronous levels and pins are open drain with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter int   TICK_CYC       = TICK_CYC_DEF,
  parameter logic EN_ACTIVE_HIGH = 1'h1
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_pushbutton_n,
  input  wire logic          i_shutdown_request_n,
  input  wire logic [15:0]   i_turn_on_extension,
  input  wire logic [15:0]   i_off_hold_extension,
  output var  logic          o_supply_o,
  output var  logic          o_supply_oe_n,
  output var  logic          o_power_down_request_o,
  output var  logic          o_power_down_request_oe_n
);
  // supply pin released (pulled) when on for active high, driven when on otherwise
  localparam logic SUP_OE_OFF = EN_ACTIVE_HIGH ? 1'h0 : 1'h1;

  pbs_state_type state_r;
  pbs_state_type state_nxt;
  logic          pb_m_r;
  logic          pb_s_r;
  logic          kill_m_r;
  logic          kill_s_r;
  logic          pb_prev_r;
  logic [KW-1:0] kill_cnt_r;
  logic          kill_low_r;
  logic          on_r;
  logic          on_nxt;
  logic          pdreq_r;
  logic          pdreq_nxt;
  logic          restart;
  logic          normal;

  pbs_tmr_if tm ();

  pbs_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .t       (tm)
  );

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pb_m_r   <= SYNC_RST;
      pb_s_r   <= SYNC_RST;
      kill_m_r <= SYNC_RST;
      kill_s_r <= SYNC_RST;
    end else begin
      pb_m_r   <= i_pushbutton_n;
      pb_s_r   <= pb_m_r;
      kill_m_r <= i_shutdown_request_n;
      kill_s_r <= kill_m_r;
    end
  end

  // previous button level for falling edge detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pb_prev_r <= SYNC_RST;
    end else begin
      pb_prev_r <= pb_s_r;
    end
  end

  // ****************************************************************
  // shutdown request pulse width filter
  // ****************************************************************
  // short dips from a divider used as a supply monitor are not a request
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kill_cnt_r <= '0;
      kill_low_r <= 1'h0;
    end else if (kill_s_r) begin
      kill_cnt_r <= '0;
      kill_low_r <= 1'h0;
    end else if (kill_cnt_r == KW'(KILL_PW_CYC - 1)) begin
      kill_low_r <= 1'h1;
    end else begin
      kill_cnt_r <= kill_cnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // timer limit per state
  // ****************************************************************
  always_comb begin
    case (state_r)
      ST_ON_DB:   tm.limit = pbs_ms(TURN_ON_DEBOUNCE_MS) + TW'(i_turn_on_extension);
      ST_BLANK:   tm.limit = pbs_ms(STARTUP_BLANKING_MS);
      ST_REL_DB:  tm.limit = pbs_ms(RELEASE_DEBOUNCE_MS);
      ST_OFF_DB:  tm.limit = pbs_ms(TURN_OFF_DEBOUNCE_MS);
      ST_REQ_MIN: tm.limit = pbs_ms(REQ_MIN_MS);
      ST_HOLD:    tm.limit = TW'(i_off_hold_extension);
      ST_LOCKOUT: tm.limit = pbs_ms(LOCKOUT_MS);
      default:    tm.limit = '0;
    endcase
  end

  // any state change or bounce restarts the timer
  assign tm.clr = (state_nxt != state_r) || restart;

  // states where a filtered shutdown request acts at once
  assign normal = (state_r == ST_REL_DB) || (state_r == ST_ON) || (state_r == ST_OFF_DB) ||
                  (state_r == ST_REQ_MIN) || (state_r == ST_HOLD);

  // ****************************************************************
  // sequence state machine
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    on_nxt    = on_r;
    pdreq_nxt = pdreq_r;
    restart   = 1'h0;
    if (normal && kill_low_r) begin
      // software shutdown wins over any button activity
      state_nxt = ST_LOCKOUT;
      on_nxt    = 1'h0;
      pdreq_nxt = 1'h0;
    end else begin
      case (state_r)
        ST_OFF: begin
          if (pb_prev_r && !pb_s_r) begin
            state_nxt = ST_ON_DB;
          end
        end
        ST_ON_DB: begin
          if (pb_s_r) begin
            state_nxt = ST_OFF;
          end else if (tm.done) begin
            state_nxt = ST_BLANK;
            on_nxt    = 1'h1;
          end
        end
        ST_BLANK: begin
          // inputs are not looked at until the blanking ends
          if (tm.done) begin
            if (kill_low_r) begin
              state_nxt = ST_OFF;
              on_nxt    = 1'h0;
            end else begin
              state_nxt = ST_REL_DB;
            end
          end
        end
        ST_REL_DB: begin
          if (!pb_s_r) begin
            restart = 1'h1;
          end else if (tm.done) begin
            state_nxt = ST_ON;
          end
        end
        ST_ON: begin
          if (pb_prev_r && !pb_s_r) begin
            state_nxt = ST_OFF_DB;
          end
        end
        ST_OFF_DB: begin
          if (pb_s_r) begin
            state_nxt = ST_ON;
          end else if (tm.done) begin
            state_nxt = ST_REQ_MIN;
            pdreq_nxt = 1'h1;
          end
        end
        ST_REQ_MIN: begin
          // request held for its minimum width whatever the button does
          if (tm.done) begin
            if (!pb_s_r) begin
              state_nxt = ST_HOLD;
            end else begin
              state_nxt = ST_ON;
              pdreq_nxt = 1'h0;
            end
          end
        end
        ST_HOLD: begin
          if (pb_s_r) begin
            state_nxt = ST_ON;
            pdreq_nxt = 1'h0;
          end else if (tm.done) begin
            // forced off; new turn-on needs a fresh falling edge
            state_nxt = ST_OFF;
            on_nxt    = 1'h0;
            pdreq_nxt = 1'h0;
          end
        end
        ST_LOCKOUT: begin
          // button ignored so the rails decay before a restart
          if (tm.done) begin
            state_nxt = ST_OFF;
          end
        end
        default: begin
          state_nxt = ST_OFF;
          on_nxt    = 1'h0;
          pdreq_nxt = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // output pins
  // ****************************************************************
  // pins driven low only; level rises through the external pull-up
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_r                      <= 1'h0;
      pdreq_r                   <= 1'h0;
      o_supply_o                <= 1'h0;
      o_supply_oe_n             <= SUP_OE_OFF;
      o_power_down_request_o    <= 1'h0;
      o_power_down_request_oe_n <= PDREQ_RST;
    end else begin
      on_r                      <= on_nxt;
      pdreq_r                   <= pdreq_nxt;
      o_supply_o                <= 1'h0;
      o_supply_oe_n             <= EN_ACTIVE_HIGH ? on_nxt : !on_nxt;
      o_power_down_request_o    <= 1'h0;
      o_power_down_request_oe_n <= !pdreq_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_off_supply: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_OFF) |-> !on_r) else $error("supply on in off state");

  a_turn_on_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(on_r) |-> $past(state_r == ST_ON_DB && tm.done && !pb_s_r))
    else $error("supply on without completed press");

  a_on_bounce: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_ON_DB && pb_s_r) |=> (state_r == ST_OFF && !on_r))
    else $error("turn-on debounce not restarted");

  a_blank_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_BLANK && !tm.done) |=> (state_r == ST_BLANK && on_r))
    else $error("blanking left early");

  a_abort_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_BLANK && tm.done && kill_low_r) |=> (!on_r && state_r == ST_OFF))
    else $error("power-on not aborted");

  // the last cycle of the minimum may legally drop the request
  a_req_minimum: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_REQ_MIN && !tm.done && !kill_low_r) |-> pdreq_r ##1 pdreq_r)
    else $error("request dropped before minimum");

  a_kill_normal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (normal && kill_low_r) |=> (!on_r && !pdreq_r && state_r == ST_LOCKOUT))
    else $error("shutdown request ignored");

  a_lockout_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_LOCKOUT && !tm.done) |=> (state_r == ST_LOCKOUT))
    else $error("lockout ended early");

  a_forced_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_HOLD && tm.done && !pb_s_r && !kill_low_r) |=> (!on_r && !pdreq_r))
    else $error("forced off failed");

  a_kill_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(kill_low_r) |-> $past(!kill_s_r) ##0 $past(kill_cnt_r) == KW'(KILL_PW_CYC - 1))
    else $error("shutdown filter too short");

  a_pin_polarity: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_supply_oe_n == (EN_ACTIVE_HIGH ? on_r : !on_r))
    else $error("supply pin polarity wrong");

  // steps after turn-on; a live shutdown request overrides each one from release debounce on,
  // so the antecedents leave that case to a_kill_normal
  a_on_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(on_r) |-> (state_r == ST_BLANK))
    else $error("supply on without blanking");

  a_rel_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_REL_DB && !pb_s_r && !kill_low_r) |=>
    (state_r == ST_REL_DB && !tm.done)) else $error("release debounce not restarted");

  a_off_bounce: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_OFF_DB && pb_s_r && !kill_low_r) |=>
    (state_r == ST_ON && !pdreq_r)) else $error("off debounce not restarted");

  a_req_raise: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_OFF_DB && tm.done && !pb_s_r && !kill_low_r) |=>
    (state_r == ST_REQ_MIN && pdreq_r)) else $error("request not raised");

  a_hold_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_REQ_MIN && tm.done && !pb_s_r && !kill_low_r) |=>
    (state_r == ST_HOLD && pdreq_r)) else $error("hold timer not started");

  a_req_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_REQ_MIN && tm.done && pb_s_r && !kill_low_r) |=>
    (state_r == ST_ON && on_r && !pdreq_r)) else $error("request outlived button");

  a_hold_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_HOLD && pb_s_r && !kill_low_r) |=>
    (state_r == ST_ON && on_r && !pdreq_r)) else $error("early release not honoured");

  a_idle_request: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_ON) |-> !pdreq_r)
    else $error("request low in idle on state");

  a_fresh_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_OFF && !(pb_prev_r && !pb_s_r)) |=> (state_r == ST_OFF))
    else $error("turn-on without falling edge");

  c_turn_on:  cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(on_r));
  c_abort:    cover property (@(posedge i_clk) disable iff (!i_rst_n)
    state_r == ST_BLANK && tm.done && kill_low_r);
  c_request:  cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(pdreq_r));
  c_forced:   cover property (@(posedge i_clk) disable iff (!i_rst_n)
    state_r == ST_HOLD && tm.done && !pb_s_r);
  c_lockout:  cover property (@(posedge i_clk) disable iff (!i_rst_n)
    state_r == ST_LOCKOUT && tm.done);
endmodule // pbs_sequencer
`default_nettype wire

//--- verif/pbs_host_model.sv
/*
  host processor and momentary pushbutton facing the power sequencer.
  assumes the bench resolves the open-drain pins with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module pbs_host_model (
  input  wire logic i_clk,
  input  wire logic i_supply_on,
  input  wire logic i_pdreq_pin,
  input  wire logic i_press,
  input  wire logic i_hold_kill,
  input  wire logic i_respond,
  input  wire logic i_glitch,
  output var  logic o_pushbutton_n,
  output var  logic o_shutdown_request_n
);
  // ****************************************************************
  // host boot and shutdown housekeeping
  // ****************************************************************
  localparam int BOOT_CYC  = 100;
  localparam int HOUSE_CYC = 20;
  int   boot_cnt  = 0;
  int   house_cnt = 0;
  logic kill_r    = 1'h0;

  // switch closes to ground, internal pull-up otherwise
  assign o_pushbutton_n = ~i_press;
  // line low while booting, after housekeeping or on bench command
  assign o_shutdown_request_n = ~(kill_r | i_hold_kill | i_glitch);

  // an unpowered host lets the line go to its pull-up
  always @(posedge i_clk) begin
    if (!i_supply_on) begin
      boot_cnt  <= 0;
      house_cnt <= 0;
      kill_r    <= 1'h0;
    end else begin
      if (boot_cnt < BOOT_CYC) begin
        boot_cnt <= boot_cnt + 1;
      end
      if (i_respond && (!i_pdreq_pin || house_cnt > 0) && house_cnt < HOUSE_CYC) begin
        house_cnt <= house_cnt + 1;
      end
      // boot ends well inside blanking, so a slow host still keeps power
      kill_r <= (boot_cnt < BOOT_CYC) || (house_cnt == HOUSE_CYC);
    end
  end
endmodule // pbs_host_model
`default_nettype wire

//--- verif/pbs_sequencer_tb_top.sv
/*
  self-checking bench for the pushbutton power sequencer.
  assumes the host model drives the shutdown line and the button.
*/
`timescale 1ns/1ps
`default_nettype none
module pbs_sequencer_tb_top;
  import pbs_pkg::*;
  // ****************************************************************
  // clock, pins and model
  // ****************************************************************
  localparam int   T  = 4;    // short tick keeps long timers cheap
  localparam logic AH = 1'h1;
  logic        i_clk;
  logic        i_rst_n;
  logic        press;
  logic        hold_kill;
  logic        respond;
  logic        glitch;
  logic [15:0] ext_on;
  logic [15:0] ext_off;
  logic        sup_o;
  logic        sup_oe_n;
  logic        pdr_o;
  logic        pdr_oe_n;
  logic        al_o;
  logic        al_oe_n;
  wire  logic  pb_n;
  wire  logic  sd_n;
  int          n_errors = 0;
  int          checked  = 0;
  // open-drain pins with pull-ups
  wire  logic  supply_pin = sup_oe_n ? 1'h1 : sup_o;
  wire  logic  pdreq_pin  = pdr_oe_n ? 1'h1 : pdr_o;
  wire  logic  al_pin     = al_oe_n ? 1'h1 : al_o;
  wire  logic  supply_on  = (supply_pin === AH);

  pbs_sequencer #(.TICK_CYC(T), .EN_ACTIVE_HIGH(AH)) dut (
    .i_clk                     (i_clk),
    .i_rst_n                   (i_rst_n),
    .i_pushbutton_n            (pb_n),
    .i_shutdown_request_n      (sd_n),
    .i_turn_on_extension       (ext_on),
    .i_off_hold_extension      (ext_off),
    .o_supply_o                (sup_o),
    .o_supply_oe_n             (sup_oe_n),
    .o_power_down_request_o    (pdr_o),
    .o_power_down_request_oe_n (pdr_oe_n)
  );

  // active-low variant on the same inputs must walk the same sequence
  pbs_sequencer #(.TICK_CYC(T), .EN_ACTIVE_HIGH(1'h0)) dut_al (
    .i_clk                     (i_clk),
    .i_rst_n                   (i_rst_n),
    .i_pushbutton_n            (pb_n),
    .i_shutdown_request_n      (sd_n),
    .i_turn_on_extension       (ext_on),
    .i_off_hold_extension      (ext_off),
    .o_supply_o                (al_o),
    .o_supply_oe_n             (al_oe_n),
    .o_power_down_request_o    (),
    .o_power_down_request_oe_n ()
  );

  pbs_host_model u_host (
    .i_clk                (i_clk),
    .i_supply_on          (supply_on),
    .i_pdreq_pin          (pdreq_pin),
    .i_press              (press),
    .i_hold_kill          (hold_kill),
    .i_respond            (respond),
    .i_glitch             (glitch),
    .o_pushbutton_n       (pb_n),
    .o_shutdown_request_n (sd_n)
  );

  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end

  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // inputs always move 10 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      0: return supply_on;
      1: return pdreq_pin;
      default: return sd_n;
    endcase
  endfunction

  // bounded wait; n is the count of edges passed
  task automatic wait_sig(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    while (probe(sel) !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  // a latency is judged within a small window, synchroniser slack included
  task automatic near(input int n, input int exp, input int tol);
    chk(32'((n >= exp - tol) && (n <= exp + tol)), 32'h1);
  endtask

  // press until on, hold on for a while, then wait out blanking and release debounce
  task automatic power_up(input int hold);
    int n;
    press = 1'h1;
    wait_sig(0, 1'h1, (40 + 32 + ext_on) * T, n);
    near(n, (32 + ext_on) * T + 3, 3);
    chk(32'(al_pin), 32'h0);
    repeat (hold) begin
      cyc(1);
      chk(32'(probe(1)), 32'h1);
    end
    press = 1'h0;
    cyc(560 * T);
    chk(32'(probe(0)), 32'h1);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(32'(probe(0)), 32'h0);
    chk(32'(probe(1)), 32'h1);
    chk(32'(al_pin), 32'h1);
  endtask

  // a bounced press restarts the count; held through blanking is no off press
  task automatic t_bounce();
    ext_on = 16'h5;
    press  = 1'h1;
    cyc(20 * T);
    press  = 1'h0;
    cyc(2 * T);
    chk(32'(probe(0)), 32'h0);
    power_up(560 * T);
  endtask

  task automatic t_request();
    int n;
    // a press shorter than the off debounce raises no request
    press = 1'h1;
    cyc(20 * T);
    press = 1'h0;
    cyc(2 * T);
    chk(32'(probe(1)), 32'h1);
    press = 1'h1;
    wait_sig(1, 1'h0, 40 * T, n);
    near(n, 32 * T + 3, 3);
    cyc(10 * T);
    press = 1'h0;
    wait_sig(1, 1'h1, 40 * T, n);
    near(n + 10 * T, 32 * T, 3);
    chk(32'(probe(0)), 32'h1);
    cyc(5 * T);
    press = 1'h1;
    wait_sig(1, 1'h0, 40 * T, n);
    cyc(44 * T);
    chk(32'(probe(1)), 32'h0);
    press = 1'h0;
    wait_sig(1, 1'h1, 8, n);
    near(n, 3, 3);
    chk(32'(probe(0)), 32'h1);
    cyc(5 * T);
  endtask

  task automatic t_forced();
    int n;
    press = 1'h1;
    wait_sig(0, 1'h0, (70 + ext_off) * T, n);
    near(n, (64 + ext_off) * T + 3, 4);
    chk(32'(probe(1)), 32'h1);
    chk(32'(al_pin), 32'h1);
    press = 1'h0;
    cyc(5 * T);
  endtask

  // host keeps the line low: blanking ignores it and the button, then aborts
  task automatic t_abort();
    int n;
    ext_on    = 16'h0;
    hold_kill = 1'h1;
    press     = 1'h1;
    wait_sig(0, 1'h1, 40 * T, n);
    near(n, 32 * T + 3, 3);
    press     = 1'h0;
    cyc(100 * T);
    press     = 1'h1;
    cyc(40 * T);
    chk(32'(probe(1)), 32'h1);
    press     = 1'h0;
    wait_sig(0, 1'h0, 400 * T, n);
    near(n + 140 * T, 512 * T, 4);
    hold_kill = 1'h0;
    cyc(5 * T);
  endtask

  task automatic t_host();
    int n;
    power_up(0);
    glitch  = 1'h1;
    cyc(100);
    glitch  = 1'h0;
    cyc(400);
    chk(32'(probe(0)), 32'h1);
    ext_off = 16'h64; // long hold so the host request acts before forced off
    respond = 1'h1;
    press   = 1'h1;
    wait_sig(1, 1'h0, 40 * T, n);
    wait_sig(2, 1'h0, 40, n);
    chk(32'(n > 0), 32'h1);
    wait_sig(0, 1'h0, 320, n);
    near(n, 304, 3);
    chk(32'(probe(1)), 32'h1);
    press   = 1'h0;
    respond = 1'h0;
    cyc(10 * T);
    press   = 1'h1;
    cyc(60 * T);
    chk(32'(probe(0)), 32'h0);
    press   = 1'h0;
    cyc(200 * T);
    power_up(0);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    i_rst_n   = 1'h0;
    press     = 1'h0;
    hold_kill = 1'h0;
    respond   = 1'h0;
    glitch    = 1'h0;
    ext_on    = 16'h0;
    ext_off   = 16'h14;
    cyc(12);
    i_rst_n   = 1'h1;
    cyc(2);
    t_reset();
    t_bounce();
    t_request();
    t_forced();
    t_abort();
    t_host();
    give_verdict();
  end

  // the whole run takes about 15000 cycles
  initial begin
    repeat (40000) @(posedge i_clk);
    n_errors++;
    give_verdict();
  end
endmodule // pbs_sequencer_tb_top
`default_nettype wire
